// ### hdl/lsba_alu.sv
// Top of the logic, shift and bit-manipulation execution unit
`timescale 1ns/100ps
`default_nettype none
module lsba_alu
    import lsba_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [4:0] op_i,
    input wire logic [1:0] size_i,
    input wire logic [31:0] dst_i,
    input wire logic [31:0] src_i,
    input wire logic [31:0] imm_i,
    input wire logic use_imm_i,
    input wire logic [2:0] bit_pos_imm_i,
    input wire logic bit_pos_from_reg_i,
    input wire logic carry_i,
    output logic ready_o,
    output logic done_o,
    output logic [31:0] result_o,
    output logic result_wr_o,
    output logic carry_o,
    output logic carry_wr_o,
    output logic zero_o,
    output logic zero_wr_o,
    output logic bad_op_o
);
    lsba_state_type state_ff;
    lsba_state_type nxt_state;
    lsba_op_type op_ff;
    lsba_size_type size_ff;
    logic [31:0] dst_ff;
    logic [31:0] opnd_ff;
    logic [2:0] pos_ff;
    logic carry_in_ff;
    logic bad_ff;

    logic ready_ff;
    logic done_ff;
    logic [31:0] result_ff;
    logic result_wr_ff;
    logic carry_ff;
    logic carry_wr_ff;
    logic zero_ff;
    logic zero_wr_ff;
    logic bad_op_ff;

    logic [31:0] nxt_result;
    logic nxt_result_wr;
    logic nxt_carry;
    logic nxt_carry_wr;
    logic nxt_zero;
    logic nxt_zero_wr;

    logic [31:0] shift_result;
    logic shift_carry;
    logic [7:0] bit_byte;
    logic bit_byte_wr;
    logic bit_carry;
    logic bit_carry_wr;
    logic bit_zero;
    logic bit_zero_wr;
    logic [31:0] mask;
    logic take;
    logic is_shift;
    logic is_logic;

    assign take = start_i && ready_ff;

    // Sequencer: idle, execute, answer
    always_comb begin
        case (state_ff)
            st_idle: nxt_state = take ? st_exec : st_idle;
            st_exec: nxt_state = st_done;
            st_done: nxt_state = st_idle;
            default: nxt_state = st_idle;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_ff <= st_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ready_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            ready_ff <= nxt_state == st_idle;
            done_ff <= nxt_state == st_done;
        end
    end

    // Operand capture; partner's values need only hold for the taking edge
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            op_ff <= logic_and_op;
            size_ff <= size_byte;
            dst_ff <= RESULT_RST;
            opnd_ff <= RESULT_RST;
            pos_ff <= BIT_POS_RST;
            carry_in_ff <= 1'b0;
            bad_ff <= 1'b0;
        end else if (take) begin
            op_ff <= lsba_op_type'(op_i);
            size_ff <= lsba_size_type'(size_i);
            dst_ff <= dst_i;
            opnd_ff <= use_imm_i ? imm_i : src_i;
            pos_ff <= bit_pos_from_reg_i ? src_i[2:0] : bit_pos_imm_i;
            carry_in_ff <= carry_i;
            // Inverted forms with a register bit number are refused
            bad_ff <= is_inv_bit_op(lsba_op_type'(op_i))
                && bit_pos_from_reg_i;
        end
    end

    lsba_shifter u_shifter (
        .op_i(op_ff),
        .size_i(size_ff),
        .data_i(dst_ff),
        .carry_i(carry_in_ff),
        .result_o(shift_result),
        .carry_o(shift_carry)
    );

    // Bit ops see the byte in the low lane, register or memory alike
    lsba_bit_unit u_bit_unit (
        .op_i(op_ff),
        .byte_i(dst_ff[7:0]),
        .pos_i(pos_ff),
        .carry_i(carry_in_ff),
        .byte_o(bit_byte),
        .byte_wr_o(bit_byte_wr),
        .carry_o(bit_carry),
        .carry_wr_o(bit_carry_wr),
        .zero_o(bit_zero),
        .zero_wr_o(bit_zero_wr)
    );

    always_comb begin
        mask = size_mask(size_ff);
        is_logic = op_ff inside {logic_and_op, logic_or_op, logic_xor_op, logic_not_op};
        is_shift = op_ff inside {arith_shift_left_op, arith_shift_right_op,
            logic_shift_left_op, logic_shift_right_op, rotate_left_op,
            rotate_right_op, rotate_carry_left_op, rotate_carry_right_op};
        nxt_result = dst_ff;
        nxt_result_wr = 1'b0;
        nxt_carry = carry_in_ff;
        nxt_carry_wr = 1'b0;
        nxt_zero = 1'b0;
        nxt_zero_wr = 1'b0;
        if (bad_ff) begin
            nxt_result = dst_ff;
        end else if (is_logic) begin
            case (op_ff)
                logic_and_op: nxt_result = dst_ff & opnd_ff;
                logic_or_op: nxt_result = dst_ff | opnd_ff;
                logic_xor_op: nxt_result = dst_ff ^ opnd_ff;
                default: nxt_result = ~dst_ff;
            endcase
            nxt_result = (dst_ff & ~mask) | (nxt_result & mask);
            nxt_result_wr = 1'b1;
        end else if (is_shift) begin
            nxt_result = shift_result;
            nxt_result_wr = 1'b1;
            nxt_carry = shift_carry;
            nxt_carry_wr = 1'b1;
        end else begin
            nxt_result = {dst_ff[31:8], bit_byte};
            nxt_result_wr = bit_byte_wr;
            nxt_carry = bit_carry;
            nxt_carry_wr = bit_carry_wr;
            nxt_zero = bit_zero;
            nxt_zero_wr = bit_zero_wr;
        end
    end

    // Answer registers; write strobes stand for the one done cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            result_ff <= RESULT_RST;
            carry_ff <= 1'b0;
            zero_ff <= 1'b0;
        end else if (state_ff == st_exec) begin
            result_ff <= nxt_result;
            carry_ff <= nxt_carry;
            zero_ff <= nxt_zero;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            result_wr_ff <= 1'b0;
            carry_wr_ff <= 1'b0;
            zero_wr_ff <= 1'b0;
            bad_op_ff <= 1'b0;
        end else begin
            result_wr_ff <= state_ff == st_exec && nxt_result_wr;
            carry_wr_ff <= state_ff == st_exec && nxt_carry_wr;
            zero_wr_ff <= state_ff == st_exec && nxt_zero_wr;
            bad_op_ff <= state_ff == st_exec && bad_ff;
        end
    end

    assign ready_o = ready_ff;
    assign done_o = done_ff;
    assign result_o = result_ff;
    assign result_wr_o = result_wr_ff;
    assign carry_o = carry_ff;
    assign carry_wr_o = carry_wr_ff;
    assign zero_o = zero_ff;
    assign zero_wr_o = zero_wr_ff;
    assign bad_op_o = bad_op_ff;

    // Checks tie the answer two edges later to the operands at the take
    logic [31:0] opnd_now;
    logic [7:0] pos_bit_mask;
    assign opnd_now = use_imm_i ? imm_i : src_i;
    assign pos_bit_mask = 8'h01 << (bit_pos_from_reg_i ? src_i[2:0] : bit_pos_imm_i);

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    a_and_long: assert property (
        take && op_i == logic_and_op && size_i == size_long |-> ##2
        done_o && result_wr_o && result_o == ($past(dst_i, 2) & $past(opnd_now, 2)))
        else $error("AND longword result wrong");

    a_or_byte_keep: assert property (
        take && op_i == logic_or_op && size_i == size_byte |-> ##2
        result_o[31:8] == $past(dst_i[31:8], 2)
        && result_o[7:0] == ($past(dst_i[7:0], 2) | $past(opnd_now[7:0], 2)))
        else $error("OR byte result or upper bits wrong");

    a_xor_word: assert property (
        take && op_i == logic_xor_op && size_i == size_word |-> ##2
        result_o[15:0] == ($past(dst_i[15:0], 2) ^ $past(opnd_now[15:0], 2)))
        else $error("XOR word result wrong");

    a_not_long: assert property (
        take && op_i == logic_not_op && size_i == size_long |-> ##2
        result_o == ~$past(dst_i, 2))
        else $error("NOT result wrong");

    a_arith_shift_right_op_byte: assert property (
        take && op_i == arith_shift_right_op && size_i == size_byte |-> ##2
        result_o[7:0] == {$past(dst_i[7], 2), $past(dst_i[7:1], 2)}
        && carry_wr_o && carry_o == $past(dst_i[0], 2))
        else $error("Arithmetic right shift wrong");

    a_logic_shift_left_op_word: assert property (
        take && op_i == logic_shift_left_op && size_i == size_word |-> ##2
        result_o[15:0] == {$past(dst_i[14:0], 2), 1'b0} && carry_o == $past(dst_i[15], 2))
        else $error("Logical left shift wrong");

    a_rotate_left_op_long: assert property (
        take && op_i == rotate_left_op && size_i == size_long |-> ##2
        result_o == {$past(dst_i[30:0], 2), $past(dst_i[31], 2)})
        else $error("Rotate left wrong");

    a_rotate_carry_right_op_word: assert property (
        take && op_i == rotate_carry_right_op && size_i == size_word |-> ##2
        result_o[15:0] == {$past(carry_i, 2), $past(dst_i[15:1], 2)}
        && carry_o == $past(dst_i[0], 2))
        else $error("Rotate through carry wrong");

    a_bit_set: assert property (
        take && op_i == bit_set_op |-> ##2
        result_wr_o && result_o[7:0] == ($past(dst_i[7:0], 2) | $past(pos_bit_mask, 2)))
        else $error("Bit set wrong");

    a_bit_test: assert property (
        take && op_i == bit_test_op |-> ##2
        zero_wr_o && !result_wr_o && zero_o == (($past(dst_i[7:0], 2)
        & $past(pos_bit_mask, 2)) == 8'h00))
        else $error("Bit test zero flag wrong");

    a_inv_reg_pos: assert property (
        take && is_inv_bit_op(lsba_op_type'(op_i)) && bit_pos_from_reg_i |-> ##2
        bad_op_o && !result_wr_o && !carry_wr_o)
        else $error("Inverted form with register bit number not refused");

    a_bit_load: assert property (
        take && op_i == bit_to_carry_op |-> ##2
        carry_wr_o && carry_o == (($past(dst_i[7:0], 2) & $past(pos_bit_mask, 2)) != 8'h00))
        else $error("Bit load wrong");

    a_ready_gap: assert property (
        take |=> !ready_o [*2] ##1 ready_o)
        else $error("Ready spacing wrong");

    c_shift_done: cover property (take && op_i == rotate_carry_left_op ##2 done_o);
    c_bit_store: cover property (take && op_i == inv_carry_to_bit_op ##2 result_wr_o);
    c_back_to_back: cover property (take ##3 take);
    c_refused: cover property (bad_op_o);
endmodule
`default_nettype wire

// ### hdl/lsba_bit_unit.sv
// Single-bit manipulation on a byte operand with carry and zero flags
`timescale 1ns/100ps
`default_nettype none
module lsba_bit_unit
    import lsba_pkg::*;
(
    input wire lsba_op_type op_i,
    input wire logic [7:0] byte_i,
    input wire logic [2:0] pos_i,
    input wire logic carry_i,
    output logic [7:0] byte_o,
    output logic byte_wr_o,
    output logic carry_o,
    output logic carry_wr_o,
    output logic zero_o,
    output logic zero_wr_o
);
    logic sel;

    always_comb begin
        sel = byte_i[pos_i];
        byte_o = byte_i;
        byte_wr_o = 1'b0;
        carry_o = carry_i;
        carry_wr_o = 1'b1;
        zero_o = 1'b0;
        zero_wr_o = 1'b0;
        case (op_i)
            bit_set_op: byte_o[pos_i] = 1'b1;
            bit_clear_op: byte_o[pos_i] = 1'b0;
            bit_invert_op: byte_o[pos_i] = ~sel;
            carry_to_bit_op: byte_o[pos_i] = carry_i;
            inv_carry_to_bit_op: byte_o[pos_i] = ~carry_i;
            carry_and_bit_op: carry_o = carry_i & sel;
            carry_and_inv_bit_op: carry_o = carry_i & ~sel;
            carry_or_bit_op: carry_o = carry_i | sel;
            carry_or_inv_bit_op: carry_o = carry_i | ~sel;
            carry_xor_bit_op: carry_o = carry_i ^ sel;
            carry_xor_inv_bit_op: carry_o = carry_i ^ ~sel;
            bit_to_carry_op: carry_o = sel;
            inv_bit_to_carry_op: carry_o = ~sel;
            bit_test_op: begin
                zero_o = ~sel;
                zero_wr_o = 1'b1;
            end
            default: carry_wr_o = 1'b0;
        endcase
        if (op_i inside {bit_set_op, bit_clear_op, bit_invert_op,
                carry_to_bit_op, inv_carry_to_bit_op}) begin
            byte_wr_o = 1'b1;
            carry_wr_o = 1'b0;
        end
        if (op_i == bit_test_op) begin
            carry_wr_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### hdl/lsba_pkg.sv
// Package: op codes, sizes, states and constants of the logic/shift/bit ALU
// Notes on behaviour
// - AND destination with register or immediate
// - OR destination with register or immediate
// - XOR destination with register or immediate
// - Complement replaces register with inverted bits
// - Arithmetic left and right shifts
// - Logical shifts fill vacated bit with zero
// - Rotates re-enter leaving bit opposite end
// - Carry rotates: carry in, leaving bit out
// - Bit number from immediate or register low bits
// - Bit set forces selected bit to one
// - Bit clear forces selected bit to zero
// - Bit invert toggles selected bit
// - Bit test loads zero with inverted bit
// - Carry AND with bit or inverted bit
// - Carry OR with bit or inverted bit
// - Carry XOR with bit or inverted bit
// - Inverted bit forms take immediate bit number only
// - Bit load copies bit or inverse to carry
// - Bit store writes carry or inverse to bit
package lsba_pkg;

    typedef enum logic [4:0] {
        logic_and_op = 5'h00, logic_or_op = 5'h01,
        logic_xor_op = 5'h02, logic_not_op = 5'h03,
        arith_shift_left_op = 5'h04, arith_shift_right_op = 5'h05,
        logic_shift_left_op = 5'h06, logic_shift_right_op = 5'h07,
        rotate_left_op = 5'h08, rotate_right_op = 5'h09,
        rotate_carry_left_op = 5'h0a, rotate_carry_right_op = 5'h0b,
        bit_set_op = 5'h0c, bit_clear_op = 5'h0d,
        bit_invert_op = 5'h0e, bit_test_op = 5'h0f,
        carry_and_bit_op = 5'h10, carry_and_inv_bit_op = 5'h11,
        carry_or_bit_op = 5'h12, carry_or_inv_bit_op = 5'h13,
        carry_xor_bit_op = 5'h14, carry_xor_inv_bit_op = 5'h15,
        bit_to_carry_op = 5'h16, inv_bit_to_carry_op = 5'h17,
        carry_to_bit_op = 5'h18, inv_carry_to_bit_op = 5'h19
    } lsba_op_type;

    typedef enum logic [1:0] {
        size_byte = 2'h0, size_word = 2'h1, size_long = 2'h2
    } lsba_size_type;

    typedef enum logic [1:0] {
        st_idle = 2'h0, st_exec = 2'h1, st_done = 2'h3
    } lsba_state_type;

    localparam logic [31:0] BYTE_MASK = 32'h0000_00ff;
    localparam logic [31:0] WORD_MASK = 32'h0000_ffff;
    localparam logic [31:0] LONG_MASK = 32'hffff_ffff;
    localparam logic [4:0] BYTE_MSB = 5'h07;
    localparam logic [4:0] WORD_MSB = 5'h0f;
    localparam logic [4:0] LONG_MSB = 5'h1f;
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;
    localparam logic [2:0] BIT_POS_RST = 3'h0;
    localparam int ANSWER_CYCLES = 2;

    function automatic logic [31:0] size_mask(input lsba_size_type s);
        if (s == size_byte) begin
            return BYTE_MASK;
        end else if (s == size_word) begin
            return WORD_MASK;
        end
        return LONG_MASK;
    endfunction

    function automatic logic [4:0] size_msb(input lsba_size_type s);
        if (s == size_byte) begin
            return BYTE_MSB;
        end else if (s == size_word) begin
            return WORD_MSB;
        end
        return LONG_MSB;
    endfunction

    function automatic logic is_inv_bit_op(input lsba_op_type op);
        return op == carry_and_inv_bit_op || op == carry_or_inv_bit_op
            || op == carry_xor_inv_bit_op || op == inv_bit_to_carry_op
            || op == inv_carry_to_bit_op;
    endfunction

endpackage

// ### hdl/lsba_shifter.sv
// One-bit shifter and rotator for byte, word and longword operands
`timescale 1ns/100ps
`default_nettype none
module lsba_shifter
    import lsba_pkg::*;
(
    input wire lsba_op_type op_i,
    input wire lsba_size_type size_i,
    input wire logic [31:0] data_i,
    input wire logic carry_i,
    output logic [31:0] result_o,
    output logic carry_o
);
    logic [4:0] msb;
    logic [31:0] mask;
    logic [31:0] body;
    logic fill;
    logic left;

    always_comb begin
        msb = size_msb(size_i);
        mask = size_mask(size_i);
        left = op_i == arith_shift_left_op || op_i == logic_shift_left_op
            || op_i == rotate_left_op || op_i == rotate_carry_left_op;
        case (op_i)
            arith_shift_right_op: fill = data_i[msb];
            rotate_left_op: fill = data_i[msb];
            rotate_right_op: fill = data_i[0];
            rotate_carry_left_op: fill = carry_i;
            rotate_carry_right_op: fill = carry_i;
            default: fill = 1'b0;
        endcase
        if (left) begin
            body = (data_i << 1) & mask;
            body[0] = fill;
            carry_o = data_i[msb];
        end else begin
            body = (data_i & mask) >> 1;
            body[msb] = fill;
            carry_o = data_i[0];
        end
        // Bits above the operand size are left as they were
        result_o = (data_i & ~mask) | body;
    end
endmodule
`default_nettype wire

// ### sim/logic_shift_bit_alu_test.sv
// Self-checking bench of the logic, shift and bit-manipulation ALU
`timescale 1ns/100ps
`default_nettype none
module logic_shift_bit_alu_test import lsba_pkg::*;;
    typedef struct {
        lsba_op_type op;
        lsba_size_type size;
        logic [31:0] b;
        logic use_imm;
        logic [2:0] pos;
        logic from_reg;
        logic cin;
        logic [31:0] res;
        logic [2:0] wr;
        logic flag;
    } lsba_row_type;

    localparam logic [31:0] DST = 32'h8765_43a5;
    localparam logic [31:0] NIL = 32'h0000_0000;

    logic sys_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic start, use_imm, pos_reg, carry_in, ready, done, result_wr, carry, carry_wr;
    logic zero, zero_wr, bad_op;
    logic [4:0] op;
    logic [1:0] size;
    logic [2:0] pos_imm;
    logic [31:0] dst, src, imm, result;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    // Fields: op, size, b (source or immediate), use_imm, pos, from_reg, cin, result, wr, flag
    lsba_row_type rows [0:30] = '{
        // Logic ops, B/W/L, register and immediate source
        '{logic_and_op,size_byte,32'h0000_00f0,1'h0,3'h0,1'h0,1'h0,32'h8765_43a0,3'h4,1'h0},
        '{logic_and_op,size_word,32'h0000_0ff0,1'h1,3'h0,1'h0,1'h0,32'h8765_03a0,3'h4,1'h0},
        '{logic_or_op,size_long,32'hffff_0000,1'h0,3'h0,1'h0,1'h0,32'hffff_43a5,3'h4,1'h0},
        '{logic_or_op,size_byte,32'h0000_000f,1'h1,3'h0,1'h0,1'h0,32'h8765_43af,3'h4,1'h0},
        '{logic_xor_op,size_word,32'hffff_ffff,1'h0,3'h0,1'h0,1'h0,32'h8765_bc5a,3'h4,1'h0},
        '{logic_xor_op,size_long,32'h0f0f_0f0f,1'h1,3'h0,1'h0,1'h0,32'h886a_4caa,3'h4,1'h0},
        '{logic_not_op,size_long,NIL,1'h0,3'h0,1'h0,1'h0,32'h789a_bc5a,3'h4,1'h0},
        // One-bit shifts and rotates, leaving bit to carry
        '{arith_shift_left_op,size_byte,NIL,1'h0,3'h0,1'h0,1'h0,32'h8765_434a,3'h6,1'h1},
        '{arith_shift_right_op,size_byte,NIL,1'h0,3'h0,1'h0,1'h0,32'h8765_43d2,3'h6,1'h1},
        '{logic_shift_left_op,size_long,NIL,1'h0,3'h0,1'h0,1'h0,32'h0eca_874a,3'h6,1'h1},
        '{logic_shift_right_op,size_long,NIL,1'h0,3'h0,1'h0,1'h0,32'h43b2_a1d2,3'h6,1'h1},
        '{rotate_left_op,size_word,NIL,1'h0,3'h0,1'h0,1'h0,32'h8765_874a,3'h6,1'h0},
        '{rotate_right_op,size_byte,NIL,1'h0,3'h0,1'h0,1'h0,32'h8765_43d2,3'h6,1'h1},
        '{rotate_carry_left_op,size_word,NIL,1'h0,3'h0,1'h0,1'h1,32'h8765_874b,3'h6,1'h0},
        '{rotate_carry_right_op,size_long,NIL,1'h0,3'h0,1'h0,1'h1,32'hc3b2_a1d2,3'h6,1'h1},
        // Bit edits, tests and carry ops on the byte
        '{bit_set_op,size_byte,NIL,1'h0,3'h6,1'h0,1'h0,32'h8765_43e5,3'h4,1'h0},
        '{bit_clear_op,size_byte,32'h0000_0007,1'h0,3'h0,1'h1,1'h0,32'h8765_4325,3'h4,1'h0},
        '{bit_invert_op,size_byte,NIL,1'h0,3'h0,1'h0,1'h0,32'h8765_43a4,3'h4,1'h0},
        '{bit_test_op,size_byte,NIL,1'h0,3'h4,1'h0,1'h0,NIL,3'h1,1'h1},
        '{bit_test_op,size_byte,32'h0000_0002,1'h0,3'h4,1'h1,1'h0,NIL,3'h1,1'h0},
        '{carry_and_bit_op,size_byte,NIL,1'h0,3'h7,1'h0,1'h1,NIL,3'h2,1'h1},
        '{carry_and_inv_bit_op,size_byte,NIL,1'h0,3'h7,1'h0,1'h1,NIL,3'h2,1'h0},
        '{carry_or_bit_op,size_byte,NIL,1'h0,3'h6,1'h0,1'h0,NIL,3'h2,1'h0},
        '{carry_or_inv_bit_op,size_byte,NIL,1'h0,3'h6,1'h0,1'h0,NIL,3'h2,1'h1},
        '{carry_xor_bit_op,size_byte,NIL,1'h0,3'h5,1'h0,1'h1,NIL,3'h2,1'h0},
        '{carry_xor_inv_bit_op,size_byte,NIL,1'h0,3'h5,1'h0,1'h1,NIL,3'h2,1'h1},
        '{bit_to_carry_op,size_byte,NIL,1'h0,3'h2,1'h0,1'h0,NIL,3'h2,1'h1},
        '{inv_bit_to_carry_op,size_byte,NIL,1'h0,3'h2,1'h0,1'h1,NIL,3'h2,1'h0},
        '{carry_to_bit_op,size_byte,NIL,1'h0,3'h6,1'h0,1'h1,32'h8765_43e5,3'h4,1'h0},
        '{inv_carry_to_bit_op,size_byte,NIL,1'h0,3'h0,1'h0,1'h1,32'h8765_43a4,3'h4,1'h0},
        '{carry_and_bit_op,size_byte,32'h0000_0003,1'h0,3'h7,1'h1,1'h1,NIL,3'h2,1'h0}
    };

    lsba_op_type inv_ops [0:4] = '{carry_and_inv_bit_op, carry_or_inv_bit_op,
        carry_xor_inv_bit_op, inv_bit_to_carry_op, inv_carry_to_bit_op};

    always #50 sys_clk_i = ~sys_clk_i;

    lsba_alu lsba_alu_i (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .start_i(start),
        .op_i(op),
        .size_i(size),
        .dst_i(dst),
        .src_i(src),
        .imm_i(imm),
        .use_imm_i(use_imm),
        .bit_pos_imm_i(pos_imm),
        .bit_pos_from_reg_i(pos_reg),
        .carry_i(carry_in),
        .ready_o(ready),
        .done_o(done),
        .result_o(result),
        .result_wr_o(result_wr),
        .carry_o(carry),
        .carry_wr_o(carry_wr),
        .zero_o(zero),
        .zero_wr_o(zero_wr),
        .bad_op_o(bad_op)
    );

    lsba_cpu_model lsba_cpu_model_i (
        .sys_clk_i(sys_clk_i),
        .ready_i(ready),
        .done_i(done),
        .result_i(result),
        .result_wr_i(result_wr),
        .carry_i(carry),
        .carry_wr_i(carry_wr),
        .zero_i(zero),
        .zero_wr_i(zero_wr),
        .bad_op_i(bad_op),
        .start_o(start),
        .op_o(op),
        .size_o(size),
        .dst_o(dst),
        .src_o(src),
        .imm_o(imm),
        .use_imm_o(use_imm),
        .bit_pos_imm_o(pos_imm),
        .bit_pos_from_reg_o(pos_reg),
        .carry_flag_o(carry_in)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_i = 1'h1;
        repeat (4) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        check(32'({ready, done, result_wr, carry, carry_wr, zero, zero_wr, bad_op}), NIL,
            "flags in reset");
        check(result, RESULT_RST, "result in reset");
        rst_i = 1'h0;
        @(negedge sys_clk_i);
        check(32'(ready), 32'h0000_0001, "ready after reset");
    endtask

    // Source and immediate always differ, so a wrong operand pick shows up
    task automatic run(input lsba_op_type o, input lsba_size_type sz, input logic [31:0] b,
        input logic ui, input logic [2:0] pos, input logic fr, input logic cin);
        lsba_cpu_model_i.issue(o, sz, DST, ui ? ~b : b, ui ? b : ~b, ui, pos, fr, cin);
        check(32'(lsba_cpu_model_i.lat), 32'(ANSWER_CYCLES), "answer latency");
        check(32'(lsba_cpu_model_i.got_busy), NIL, "ready while busy");
        check(32'(lsba_cpu_model_i.got_after), 32'h0000_0001, "done pulse and ready after");
    endtask

    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            $display("wrong value at %0t: run did not finish", $time);
            end_sim();
        end
    end

    initial begin
        do_reset();
        foreach (rows[k]) begin
            run(rows[k].op, rows[k].size, rows[k].b, rows[k].use_imm, rows[k].pos,
                rows[k].from_reg, rows[k].cin);
            check(32'(lsba_cpu_model_i.got_wr), 32'(rows[k].wr), "strobes");
            check(32'(lsba_cpu_model_i.got_bad), NIL, "refusal");
            if (rows[k].wr[2]) begin
                check(lsba_cpu_model_i.got_res, rows[k].res, "result");
            end
            if (rows[k].wr[1]) begin
                check(32'(lsba_cpu_model_i.got_carry), 32'(rows[k].flag), "carry");
            end
            if (rows[k].wr[0]) begin
                check(32'(lsba_cpu_model_i.got_zero), 32'(rows[k].flag), "zero");
            end
        end
        // Inverted forms refuse a register bit number
        foreach (inv_ops[k]) begin
            run(inv_ops[k], size_byte, 32'h0000_0001, 1'h0, 3'h1, 1'h1, 1'h1);
            check(32'(lsba_cpu_model_i.got_bad), 32'h0000_0001, "refused form");
            check(32'(lsba_cpu_model_i.got_wr), NIL, "writes on refusal");
        end
        run(logic_not_op, size_word, NIL, 1'h0, 3'h0, 1'h0, 1'h0);
        check(lsba_cpu_model_i.got_res, 32'h8765_bc5a, "result before reset");
        do_reset();
        end_sim();
    end
endmodule
`default_nettype wire

// ### sim/lsba_cpu_model.sv
// Requesting side model: drives one operation's operands into the ALU and samples its answer
`timescale 1ns/100ps
`default_nettype none
module lsba_cpu_model (
    input wire logic sys_clk_i,
    input wire logic ready_i,
    input wire logic done_i,
    input wire logic [31:0] result_i,
    input wire logic result_wr_i,
    input wire logic carry_i,
    input wire logic carry_wr_i,
    input wire logic zero_i,
    input wire logic zero_wr_i,
    input wire logic bad_op_i,
    output logic start_o,
    output logic [4:0] op_o,
    output logic [1:0] size_o,
    output logic [31:0] dst_o,
    output logic [31:0] src_o,
    output logic [31:0] imm_o,
    output logic use_imm_o,
    output logic [2:0] bit_pos_imm_o,
    output logic bit_pos_from_reg_o,
    output logic carry_flag_o
);
    logic [31:0] got_res;
    logic [2:0] got_wr;
    logic got_carry;
    logic got_zero;
    logic got_bad;
    logic got_busy;
    logic [1:0] got_after;
    int lat;

    initial begin
        start_o = 1'h0;
        op_o = 5'h00;
        size_o = 2'h0;
        dst_o = 32'h0000_0000;
        src_o = 32'h0000_0000;
        imm_o = 32'h0000_0000;
        use_imm_o = 1'h0;
        bit_pos_imm_o = 3'h0;
        bit_pos_from_reg_o = 1'h0;
        carry_flag_o = 1'h0;
    end

    // Must be entered at a falling edge; leaves at a falling edge
    task automatic issue(input logic [4:0] op, input logic [1:0] size, input logic [31:0] dst,
        input logic [31:0] src, input logic [31:0] imm, input logic use_imm,
        input logic [2:0] pos, input logic from_reg, input logic cin);
        int n;
        start_o = 1'h1;
        op_o = op;
        size_o = size;
        dst_o = dst;
        src_o = src;
        imm_o = imm;
        use_imm_o = use_imm;
        bit_pos_imm_o = pos;
        bit_pos_from_reg_o = from_reg;
        carry_flag_o = cin;
        n = 0;
        @(posedge sys_clk_i);
        while (ready_i !== 1'h1 && n < 20) begin
            n++;
            @(posedge sys_clk_i);
        end
        @(negedge sys_clk_i);
        got_busy = ready_i;
        start_o = 1'h0;
        // Operands are only valid at the take edge, so spoil them afterwards
        op_o = ~op;
        size_o = ~size;
        dst_o = ~dst;
        src_o = ~src;
        imm_o = ~imm;
        use_imm_o = ~use_imm;
        bit_pos_imm_o = ~pos;
        bit_pos_from_reg_o = ~from_reg;
        carry_flag_o = ~cin;
        lat = 1;
        while (done_i !== 1'h1 && lat < 10) begin
            @(negedge sys_clk_i);
            lat++;
        end
        got_res = result_i;
        got_wr = {result_wr_i, carry_wr_i, zero_wr_i};
        got_carry = carry_i;
        got_zero = zero_i;
        got_bad = bad_op_i;
        @(negedge sys_clk_i);
        got_after = {done_i, ready_i};
    endtask
endmodule
`default_nettype wire
